/* File: core/ndiag_pkg.sv */
// Purpose: shared constants and types for the network diagnostic status block
// Assumes: 10 MHz core clock, 32-bit Avalon-MM slave with byte addresses
// Notes:   registers hold eight bits in the low byte of each word
`default_nettype none
package ndiag_pkg;
  // core clock and line idle time
  localparam int CLK_PERIOD_NS  = 100;
  localparam int LINE_IDLE_NS   = 41000;
  localparam int LINE_IDLE_CYC  = (LINE_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // refusal counts that mark an excessive run
  localparam logic [7:0] NAK_LIMIT_LONG  = 8'h80;
  localparam logic [7:0] NAK_LIMIT_SHORT = 8'h04;
  // register byte offsets
  localparam logic [4:0] ADDR_DIAG = 5'h00;
  localparam logic [4:0] ADDR_MASK = 5'h04;
  localparam logic [4:0] ADDR_IRQ  = 5'h08;
  localparam logic [4:0] ADDR_NEXT = 5'h0c;
  localparam logic [4:0] ADDR_TENT = 5'h10;
  localparam logic [4:0] ADDR_NODE = 5'h14;
  localparam logic [4:0] ADDR_CTRL = 5'h18;
  // diagnostic status bit positions
  localparam int DIAG_SELF_RECONFIGURATION_FLAG = 7;
  localparam int DIAG_DUPLICATE  = 6;
  localparam int DIAG_RX_ACT     = 5;
  localparam int DIAG_TOKEN_SEEN = 4;
  localparam int DIAG_EXCESS     = 3;
  localparam int DIAG_TENTATIVE  = 2;
  localparam int DIAG_SUCCESSOR  = 1;
  localparam int DIAG_RESERVED   = 0;
  // interrupt status and mask bit positions
  localparam int IRQ_SUCCESSOR = 1;
  localparam int IRQ_RECONFIGURATION_FLAG     = 2;
  localparam int IRQ_EXCESS    = 3;
  // control register bit positions
  localparam int CTRL_CLR_FLAGS = 0;
  localparam int CTRL_POR_CLR   = 1;
  localparam int CTRL_SOFT_RST  = 2;
  localparam int CTRL_NAK_SHORT = 3;
  localparam int CTRL_TX_EN     = 4;
  localparam int CTRL_RECONFIGURATION_FLAG     = 5;
  localparam int WORD_LANE      = 0;
  // reset values
  localparam logic [7:0] REG_RST  = 8'h00;
  localparam logic [1:0] SYNC_RST = 2'h0;
  // bus slave states
  typedef enum logic {
    NDIAG_BUS_IDLE = 1'b0,
    NDIAG_BUS_ANS  = 1'b1
  } ndiag_bus_e;
endpackage
`default_nettype wire

/* File: core/ndiag_line_mon.sv */
// Purpose: receive line monitor, synchronises the serial input and times idle
// Assumes: rst_n is already synchronised to clk_sys
// Notes:   idle_expire pulses once per idle stretch
`default_nettype none
module ndiag_line_mon #(
  parameter int IDLE_CYCLES = ndiag_pkg::LINE_IDLE_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic serial_receive_input,
  output logic      rx_active,
  output logic      idle_expire
);
  import ndiag_pkg::*;
  localparam int CW = $clog2(IDLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(IDLE_CYCLES - 1);

  typedef struct packed {
    logic [1:0]    sync;
    logic [CW-1:0] cnt;
    logic          fired;
    logic          expire;
  } ndiag_mon_s;

  ndiag_mon_s s_q;
  ndiag_mon_s s_d;

  // two-stage sync, then count cycles of a quiet line
  always_comb begin
    s_d        = s_q;
    s_d.sync   = {s_q.sync[0], serial_receive_input};
    s_d.expire = 1'b0;
    if (s_q.sync[1]) begin
      s_d.cnt   = '0;
      s_d.fired = 1'b0;
    end else if (!s_q.fired) begin
      if (s_q.cnt == LAST) begin
        s_d.expire = 1'b1;
        s_d.fired  = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + CW'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rx_active   = s_q.sync[1];
  assign idle_expire = s_q.expire;
endmodule // ndiag_line_mon
`default_nettype wire

/* File: core/ndiag_status.sv */
// Purpose: diagnostic status register bank with interrupt status and mask
// Assumes: event inputs are one-cycle pulses from logic on clk_sys
// Notes:   one wait state on every Avalon access
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`default_nettype none
module ndiag_status (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        lost_token_timeout,
  input  wire logic [7:0]  token_did_first,
  input  wire logic [7:0]  token_did_second,
  input  wire logic        token_trailing_ok,
  input  wire logic        token_response,
  input  wire logic        token_to_self,
  input  wire logic        foreign_token,
  input  wire logic        enquiry_start,
  input  wire logic        refusal_nak,
  input  wire logic        next_id_load,
  input  wire logic [7:0]  next_id_value,
  input  wire logic        serial_receive_input,
  output logic      [7:0]  node_id,
  output logic             tx_enable,
  output logic             irq
);
  import ndiag_pkg::*;

  typedef struct packed {
    ndiag_bus_e st;
    logic [7:0] rdata;
    logic [7:0] diag;
    logic       reconfiguration_flag;
    logic [7:0] mask;
    logic [7:0] irqs;
    logic [7:0] next_id;
    logic [7:0] tent_id;
    logic [7:0] node_id;
    logic       nak_short;
    logic       tx_en;
    logic [7:0] nak_cnt;
  } ndiag_state_s;

  ndiag_state_s s_q;
  ndiag_state_s s_d;
  logic [1:0]   rst_sync_q;
  logic         rst_n;
  logic         rx_active;
  logic         idle_expire;

  // decoded accesses and events
  logic       acc;
  logic       rd_diag;
  logic       rd_next;
  logic       wr_ok;
  logic [7:0] wdata;
  logic       dup_set;
  logic       tent_set;
  logic       nak_hit;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a[4:2] == off[4:2];
  endfunction

  function automatic logic [7:0] nak_limit(input logic short_sel);
    return short_sel ? NAK_LIMIT_SHORT : NAK_LIMIT_LONG;
  endfunction

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= SYNC_RST;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ndiag_line_mon #(
    .IDLE_CYCLES (LINE_IDLE_CYC)
  ) u_line_mon (
    .clk_sys              (clk_sys),
    .rst_n                (rst_n),
    .serial_receive_input (serial_receive_input),
    .rx_active            (rx_active),
    .idle_expire          (idle_expire)
  );

  // bus strobes: the access is taken in the answer state
  assign acc     = (s_q.st == NDIAG_BUS_ANS);
  assign rd_diag = acc && avs_read && hit(avs_address, ADDR_DIAG);
  assign rd_next = acc && avs_read && hit(avs_address, ADDR_NEXT);
  assign wr_ok   = acc && avs_write && avs_byteenable[WORD_LANE];
  assign wdata   = avs_writedata[7:0];

  assign dup_set = (token_response && token_trailing_ok
                    && token_did_first == s_q.node_id
                    && token_did_second == s_q.node_id)
                   || (token_to_self && s_q.tx_en);
  // tentative id checks first byte only
  assign tent_set = token_response && token_did_first == s_q.tent_id;
  // refusal count reaches the selected limit
  assign nak_hit = refusal_nak && !enquiry_start
                   && s_q.nak_cnt == nak_limit(s_q.nak_short) - 8'h01;

  // set and clear vectors for the diagnostic flags
  always_comb begin
    set_v = REG_RST;
    clr_v = REG_RST;
    set_v[DIAG_SELF_RECONFIGURATION_FLAG] = lost_token_timeout;
    set_v[DIAG_DUPLICATE]  = dup_set;
    set_v[DIAG_RX_ACT]     = rx_active;
    set_v[DIAG_TOKEN_SEEN] = foreign_token;
    set_v[DIAG_EXCESS]     = nak_hit;
    set_v[DIAG_TENTATIVE]  = tent_set;
    set_v[DIAG_SUCCESSOR]  = next_id_load;
    // read clears only the duplicate bit the host saw
    clr_v[DIAG_DUPLICATE]  = rd_diag && s_q.rdata[DIAG_DUPLICATE];
    // next id read clears successor flag
    clr_v[DIAG_SUCCESSOR]  = rd_next;
    // excessive flag clears only on power-on clear or soft reset
    clr_v[DIAG_EXCESS]     = wr_ok && hit(avs_address, ADDR_CTRL)
                             && wdata[CTRL_POR_CLR];
    if (wr_ok && hit(avs_address, ADDR_CTRL) && wdata[CTRL_SOFT_RST]) begin
      clr_v = 8'hff;
    end
  end

  // next state of the whole bank
  always_comb begin
    s_d = s_q;
    // bus handshake and read data capture
    case (s_q.st)
      NDIAG_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          s_d.st = NDIAG_BUS_ANS;
        end
        if (avs_read) begin
          s_d.rdata = REG_RST;
          if (hit(avs_address, ADDR_DIAG)) begin
            s_d.rdata = s_q.diag;
          end
          if (hit(avs_address, ADDR_MASK)) begin
            s_d.rdata = s_q.mask;
          end
          if (hit(avs_address, ADDR_IRQ)) begin
            s_d.rdata = s_q.irqs;
          end
          if (hit(avs_address, ADDR_NEXT)) begin
            s_d.rdata = s_q.next_id;
          end
          if (hit(avs_address, ADDR_TENT)) begin
            s_d.rdata = s_q.tent_id;
          end
          if (hit(avs_address, ADDR_NODE)) begin
            s_d.rdata = s_q.node_id;
          end
          if (hit(avs_address, ADDR_CTRL)) begin
            s_d.rdata[CTRL_NAK_SHORT] = s_q.nak_short;
            s_d.rdata[CTRL_TX_EN]     = s_q.tx_en;
            s_d.rdata[CTRL_RECONFIGURATION_FLAG]     = s_q.reconfiguration_flag;
          end
          s_d.rdata[DIAG_RESERVED] = s_d.rdata[DIAG_RESERVED]
                                     && !hit(avs_address, ADDR_DIAG);
        end
      end
      NDIAG_BUS_ANS: begin
        s_d.st = NDIAG_BUS_IDLE;
      end
      default: begin
        s_d.st = NDIAG_BUS_IDLE;
      end
    endcase
    // software-written registers
    if (wr_ok && hit(avs_address, ADDR_MASK)) begin
      s_d.mask = wdata;
    end
    if (wr_ok && hit(avs_address, ADDR_TENT)) begin
      s_d.tent_id = wdata;
    end
    if (wr_ok && hit(avs_address, ADDR_NODE)) begin
      s_d.node_id = wdata;
    end
    if (wr_ok && hit(avs_address, ADDR_CTRL)) begin
      s_d.nak_short = wdata[CTRL_NAK_SHORT];
      s_d.tx_en     = wdata[CTRL_TX_EN];
    end
    if (next_id_load) begin
      s_d.next_id = next_id_value;
    end
    // refusal counter, restarted by each enquiry
    if (enquiry_start) begin
      s_d.nak_cnt = REG_RST;
    end else if (refusal_nak && !nak_hit) begin
      s_d.nak_cnt = s_q.nak_cnt + 8'h01;
    end else if (nak_hit) begin
      s_d.nak_cnt = REG_RST;
    end
    s_d.diag = (s_q.diag & ~clr_v) | set_v;
    s_d.diag[DIAG_RESERVED] = 1'b0;
    if (wr_ok && hit(avs_address, ADDR_CTRL)
        && (wdata[CTRL_CLR_FLAGS] || wdata[CTRL_POR_CLR] || wdata[CTRL_SOFT_RST])) begin
      s_d.reconfiguration_flag = 1'b0;
    end
    if (idle_expire) begin
      s_d.reconfiguration_flag = 1'b1;
    end
    // sticky interrupt bits: write one clears, new rise sets
    if (wr_ok && hit(avs_address, ADDR_IRQ)) begin
      s_d.irqs = s_q.irqs & ~wdata;
    end
    if (s_d.reconfiguration_flag && !s_q.reconfiguration_flag) begin
      s_d.irqs[IRQ_RECONFIGURATION_FLAG] = 1'b1;
    end
    if (s_d.diag[DIAG_EXCESS] && !s_q.diag[DIAG_EXCESS]) begin
      s_d.irqs[IRQ_EXCESS] = 1'b1;
    end
    if (s_d.diag[DIAG_SUCCESSOR] && !s_q.diag[DIAG_SUCCESSOR]) begin
      s_d.irqs[IRQ_SUCCESSOR] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign avs_waitrequest = (avs_read || avs_write) && (s_q.st == NDIAG_BUS_IDLE);
  assign avs_readdata    = {24'h000000, s_q.rdata};
  assign node_id         = s_q.node_id;
  assign tx_enable       = s_q.tx_en;
  // unmasked sticky bits raise the line
  assign irq             = |(s_q.irqs & s_q.mask);

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_self_reconfiguration_flag_set: assert property (
    lost_token_timeout |=> s_q.diag[DIAG_SELF_RECONFIGURATION_FLAG])
    else $error("self reconfiguration_flag flag not set");
  chk_dup_match_set: assert property (
    token_response && token_trailing_ok && token_did_first == s_q.node_id
    && token_did_second == s_q.node_id |=> s_q.diag[DIAG_DUPLICATE])
    else $error("duplicate flag missed a match");
  chk_dup_online_set: assert property (
    token_to_self && s_q.tx_en |=> s_q.diag[DIAG_DUPLICATE])
    else $error("duplicate flag missed own token");
  chk_dup_read_clear: assert property (
    rd_diag && s_q.rdata[DIAG_DUPLICATE] && !dup_set
    |=> !s_q.diag[DIAG_DUPLICATE])
    else $error("duplicate flag survived a read");
  chk_rx_activity: assert property (
    rx_active |=> s_q.diag[DIAG_RX_ACT])
    else $error("receive activity not flagged");
  chk_token_seen: assert property (
    foreign_token |=> s_q.diag[DIAG_TOKEN_SEEN])
    else $error("foreign token not flagged");
  chk_nak_short_limit: assert property (
    s_q.nak_short && !s_q.diag[DIAG_EXCESS] && enquiry_start ##1
    (refusal_nak && !enquiry_start && !wr_ok)[*4] |=> s_q.diag[DIAG_EXCESS])
    else $error("four refusals did not flag");
  chk_excess_hold: assert property (
    s_q.diag[DIAG_EXCESS] && !clr_v[DIAG_EXCESS] |=> s_q.diag[DIAG_EXCESS])
    else $error("excessive flag lost without clear");
  chk_tent_match: assert property (
    tent_set |=> s_q.diag[DIAG_TENTATIVE])
    else $error("tentative flag not set");
  chk_next_set: assert property (
    next_id_load |=> s_q.diag[DIAG_SUCCESSOR] && s_q.next_id == $past(next_id_value))
    else $error("successor flag or value wrong");
  chk_next_clear: assert property (
    rd_next && !next_id_load |=> !s_q.diag[DIAG_SUCCESSOR])
    else $error("successor flag survived next id read");
  chk_resv_zero: assert property (
    rd_diag |-> avs_readdata[DIAG_RESERVED] == 1'b0)
    else $error("reserved bit read high");
  chk_idle_reconfiguration_flag: assert property (
    idle_expire |=> s_q.reconfiguration_flag ##0 (s_q.irqs[IRQ_RECONFIGURATION_FLAG] || $past(s_q.reconfiguration_flag)))
    else $error("idle timeout did not flag");
  chk_set_wins: assert property (
    rd_diag && dup_set |=> s_q.diag[DIAG_DUPLICATE])
    else $error("set lost against read clear");
  chk_excess_irq: assert property (
    nak_hit && !s_q.diag[DIAG_EXCESS] |=> s_q.irqs[IRQ_EXCESS])
    else $error("excessive flag raised no interrupt");
  chk_succ_irq: assert property (
    next_id_load && !s_q.diag[DIAG_SUCCESSOR] |=> s_q.irqs[IRQ_SUCCESSOR])
    else $error("successor flag raised no interrupt");
  chk_reset_clear: assert property (
    $rose(rst_n) |-> s_q.diag == REG_RST && !s_q.reconfiguration_flag)
    else $error("flags not clear after reset");
  chk_bus_one_wait: assert property (
    (avs_read || avs_write) && s_q.st == NDIAG_BUS_IDLE |=> !avs_waitrequest)
    else $error("access not answered in two cycles");

  cov_dup_read: cover property (s_q.diag[DIAG_DUPLICATE] ##1 rd_diag);
  cov_excess_irq: cover property ($rose(s_q.diag[DIAG_EXCESS]) ##1 irq);
  cov_next_cycle: cover property (next_id_load ##[1:20] rd_next);
  cov_idle_reconfiguration_flag: cover property (idle_expire);
  cov_nak_burst: cover property (enquiry_start ##1 refusal_nak[*4]);
endmodule // ndiag_status
`default_nettype wire

/* File: verif/ndiag_net_model.sv */
// Purpose: network side model, launches event pulses toward the block
// Assumes: tasks are called just after a rising edge of clk_sys
// Notes:   id bytes show the inverse once a fire pulse ends
`default_nettype none
module ndiag_net_model (
  input  wire logic       clk_sys,
  output logic      [6:0] ev,
  output logic      [7:0] did1,
  output logic      [7:0] did2,
  output logic            trail,
  output logic            line
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet network at time zero
  initial begin
    ev = 7'h00;
    did1 = 8'h00;
    did2 = 8'h00;
    trail = 1'b0;
    line = 1'b0;
  end
  // one-cycle pulse of the chosen events, bytes valid only with it
  task automatic fire(input logic [6:0] e, input logic [7:0] a, input logic [7:0] b,
                      input logic t);
    @(posedge clk_sys);
    ev <= e;
    did1 <= a;
    did2 <= b;
    trail <= t;
    @(posedge clk_sys);
    ev <= 7'h00;
    did1 <= ~a; // stale bytes must not look valid
    did2 <= ~b;
    trail <= ~t;
  endtask
  // one cycle of e, then f held for n back-to-back cycles
  task automatic burst(input logic [6:0] e, input logic [6:0] f, input int n);
    @(posedge clk_sys);
    ev <= e;
    @(posedge clk_sys);
    ev <= f;
    repeat (n) @(posedge clk_sys);
    ev <= 7'h00;
  endtask
  // receive line level
  task automatic drive_line(input logic v);
    @(posedge clk_sys);
    line <= v;
  endtask
endmodule // ndiag_net_model
`default_nettype wire

/* File: verif/network_diag_status_tb.sv */
// Purpose: self-checking bench for the diagnostic status register bank
// Assumes: one wait state per access, events are one-cycle pulses except the four-cycle refusal burst in t_nak
// Notes:   the host side is played by the bus tasks here
`default_nettype none
module network_diag_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ndiag_pkg::*;
  localparam logic [6:0] ev_lost = 7'h01, ev_rsp = 7'h02, ev_self = 7'h04;
  localparam logic [6:0] ev_for = 7'h08, ev_enq = 7'h10, ev_nak = 7'h20, ev_nxt = 7'h40;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic [7:0]  node_id;
  logic        tx_en;
  logic        irq;
  logic [6:0]  ev;
  logic [7:0]  did1;
  logic [7:0]  did2;
  logic        trail;
  logic        line;
  logic [31:0] q;
  int          num_errors = 0;
  int          comparisons = 0;
  // core clock
  always #50 clk_sys = ~clk_sys;
  ndiag_status uut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .lost_token_timeout(ev[0]), .token_did_first(did1),
    .token_did_second(did2), .token_trailing_ok(trail), .token_response(ev[1]),
    .token_to_self(ev[2]), .foreign_token(ev[3]), .enquiry_start(ev[4]),
    .refusal_nak(ev[5]), .next_id_load(ev[6]), .next_id_value(did1),
    .serial_receive_input(line), .node_id(node_id), .tx_enable(tx_en), .irq(irq));
  ndiag_net_model net (.clk_sys(clk_sys), .ev(ev), .did1(did1), .did2(did2),
    .trail(trail), .line(line));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    logic wq;
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    // sample waitrequest and read data at the rising edge itself
    do begin
      @(posedge clk_sys);
      wq = wreq;
      q = rdata;
    end while (wq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'h0);
    check(q, {24'h0, e});
  endtask
  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk_sys);
    check({31'h0, irq}, {31'h0, e});
    @(posedge clk_sys);
  endtask
  task automatic t_reset;
    rchk(ADDR_DIAG, 8'h00);
    irq_is(1'b0);
    rchk(5'h1c, 8'h00);
    bus(1'b1, ADDR_MASK, 8'hff, 4'h0);
    rchk(ADDR_MASK, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_events;
    net.fire(ev_lost, 8'h00, 8'h00, 1'b0);
    rchk(ADDR_DIAG, 8'h80);
    net.fire(ev_for, 8'h00, 8'h00, 1'b0);
    rchk(ADDR_DIAG, 8'h90);
    net.drive_line(1'b1);
    repeat (6) @(posedge clk_sys);
    rchk(ADDR_DIAG, 8'hb0);
    rchk(ADDR_DIAG, 8'hb0);
    $display("test events done");
  endtask
  task automatic t_dup;
    wreg(ADDR_CTRL, 8'h04);
    // transmitter off while the duplicate flag is trusted
    wreg(ADDR_NODE, 8'h2a);
    check({24'h0, node_id}, 32'h2a);
    net.fire(ev_rsp, 8'h2a, 8'h2b, 1'b1);
    rchk(ADDR_DIAG, 8'h20);
    net.fire(ev_rsp, 8'h2a, 8'h2a, 1'b0);
    rchk(ADDR_DIAG, 8'h20);
    net.fire(ev_rsp, 8'h2a, 8'h2a, 1'b1);
    rchk(ADDR_DIAG, 8'h60);
    rchk(ADDR_DIAG, 8'h20);
    wreg(ADDR_TENT, 8'h33);
    net.fire(ev_rsp, 8'h33, 8'h00, 1'b0);
    rchk(ADDR_DIAG, 8'h24);
    wreg(ADDR_CTRL, 8'h10);
    check({31'h0, tx_en}, 32'h1);
    net.fire(ev_self, 8'h00, 8'h00, 1'b0);
    rchk(ADDR_DIAG, 8'h64);
    net.fire(ev_self, 8'h00, 8'h00, 1'b0);
    fork
      rchk(ADDR_DIAG, 8'h64);
      net.fire(ev_self, 8'h00, 8'h00, 1'b0);
    join
    rchk(ADDR_DIAG, 8'h64);
    rchk(ADDR_DIAG, 8'h24);
    $display("test duplicate done");
  endtask
  task automatic t_nak;
    wreg(ADDR_CTRL, 8'h04);
    wreg(ADDR_CTRL, 8'h08);
    net.fire(ev_enq, 8'h00, 8'h00, 1'b0);
    repeat (3) net.fire(ev_nak, 8'h00, 8'h00, 1'b0);
    rchk(ADDR_DIAG, 8'h20);
    net.fire(ev_nak, 8'h00, 8'h00, 1'b0);
    rchk(ADDR_DIAG, 8'h28);
    rchk(ADDR_DIAG, 8'h28);
    wreg(ADDR_MASK, 8'h08);
    irq_is(1'b1);
    wreg(ADDR_MASK, 8'h00);
    irq_is(1'b0);
    wreg(ADDR_CTRL, 8'h02);
    rchk(ADDR_DIAG, 8'h20);
    net.fire(ev_enq, 8'h00, 8'h00, 1'b0);
    repeat (127) net.fire(ev_nak, 8'h00, 8'h00, 1'b0);
    rchk(ADDR_DIAG, 8'h20);
    net.fire(ev_nak, 8'h00, 8'h00, 1'b0);
    rchk(ADDR_DIAG, 8'h28);
    wreg(ADDR_CTRL, 8'h0a);
    rchk(ADDR_DIAG, 8'h20);
    net.burst(ev_enq, ev_nak, 4);
    rchk(ADDR_DIAG, 8'h28);
    $display("test refusal done");
  endtask
  task automatic t_succ;
    wreg(ADDR_CTRL, 8'h04);
    net.fire(ev_nxt, 8'h5c, 8'h00, 1'b0);
    rchk(ADDR_DIAG, 8'h22);
    rchk(ADDR_DIAG, 8'h22);
    wreg(ADDR_MASK, 8'h02);
    irq_is(1'b1);
    rchk(ADDR_NEXT, 8'h5c);
    rchk(ADDR_DIAG, 8'h20);
    wreg(ADDR_IRQ, 8'h02);
    irq_is(1'b0);
    $display("test successor done");
  endtask
  task automatic t_idle;
    wreg(ADDR_CTRL, 8'h04);
    wreg(ADDR_IRQ, 8'hff);
    net.drive_line(1'b0);
    repeat (420) @(posedge clk_sys);
    rchk(ADDR_CTRL, 8'h20);
    rchk(ADDR_IRQ, 8'h04);
    bus(1'b0, ADDR_DIAG, 8'h00, 4'h0);
    check(q & 32'h80, 32'h0);
    wreg(ADDR_CTRL, 8'h01);
    rchk(ADDR_CTRL, 8'h00);
    net.fire(ev_lost | ev_for, 8'h00, 8'h00, 1'b0);
    wreg(ADDR_CTRL, 8'h04);
    rchk(ADDR_DIAG, 8'h00);
    $display("test idle done");
  endtask
  task automatic give_verdict;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end
  // reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_events();
    t_dup();
    t_nak();
    t_succ();
    t_idle();
    give_verdict();
  end
endmodule // network_diag_status_tb
`default_nettype wire
